// ---- rtl/rcs_pkg.sv ----
// rcs_pkg: shared constants and types of the reset cause and sequencer block.
// assumes a 100 MHz system clock and a 32-bit APB register port.
package rcs_pkg;
   // ---------------------------------------------------------------
   // register map and field layout
   // ---------------------------------------------------------------
   localparam logic [11:0] RCC_ADDR  = 12'h000;  // reset_cause_control
   localparam logic [11:0] SEQ_ADDR  = 12'h004;  // sequencer status, read only
   localparam int TRAP_B  = 15;
   localparam int ILL_B   = 14;
   localparam int CM_B    = 9;
   localparam int VREG_B  = 8;
   localparam int EXT_B   = 7;
   localparam int SWR_B   = 6;
   localparam int WDTEN_B = 5;
   localparam int WATCHDOG_TIMEOUT_FLAG_B  = 4;
   localparam int SLP_B   = 3;
   localparam int IDL_B   = 2;
   localparam int BOR_B   = 1;
   localparam int POR_B   = 0;
   localparam logic [15:0] RCC_RST   = 16'h0003;  // power-on value
   localparam logic [15:0] RCC_WMASK = 16'hc3ff;  // implemented bits
   localparam logic [15:0] BOR_KEEP  = 16'h01a1;  // bits a brown-out leaves alone
   // ---------------------------------------------------------------
   // timing: figures in ns, cycles derived from the clock period
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int POR_EXT_NS    = 30000;
   localparam int BOR_EXT_NS    = 100000;
   localparam int POWERUP_TIMER_NS       = 64000000;
   localparam int LOCK_NS       = 1500000;
   localparam int CLOCK_FAIL_MONITOR_NS       = 900000;
   localparam int OSCD_FRC_NS   = 1100;
   localparam int OSCD_LOW_POWER_INTERNAL_OSC_NS  = 70000;
   localparam int POR_EXT_CYC   = POR_EXT_NS / CLK_PERIOD_NS;
   localparam int BOR_EXT_CYC   = BOR_EXT_NS / CLK_PERIOD_NS;
   localparam int POWERUP_TIMER_CYC      = POWERUP_TIMER_NS / CLK_PERIOD_NS;
   localparam int LOCK_CYC      = LOCK_NS / CLK_PERIOD_NS;
   localparam int CLOCK_FAIL_MONITOR_CYC      = CLOCK_FAIL_MONITOR_NS / CLK_PERIOD_NS;
   localparam int OSCD_FRC_CYC  = OSCD_FRC_NS / CLK_PERIOD_NS;
   localparam int OSCD_LOW_POWER_INTERNAL_OSC_CYC = OSCD_LOW_POWER_INTERNAL_OSC_NS / CLK_PERIOD_NS;
   localparam int OST_PERIODS   = 1024;
   localparam int CNT_W         = 23;
   // ---------------------------------------------------------------
   // clock select codes and what each mode needs before it is ready
   // 0 fast rc, 1 fast rc pll, 2 crystal, 3 crystal pll,
   // 4 secondary crystal, 5 low power rc, 6 ext clock, 7 ext clock pll
   // ---------------------------------------------------------------
   localparam logic [2:0] MODE_LOW_POWER_INTERNAL_OSC = 3'h5;
   localparam logic [7:0] OSCD_MASK = 8'h3f;
   localparam logic [7:0] OST_MASK  = 8'h1c;
   localparam logic [7:0] PLL_MASK  = 8'h8a;
   // ---------------------------------------------------------------
   // sequencer states and bus carriers
   // ---------------------------------------------------------------
   typedef enum logic [7:0] {
      ST_HOLD = 8'h01, ST_EXT  = 8'h02, ST_POWERUP_TIMER = 8'h04, ST_OSCD = 8'h08,
      ST_OST  = 8'h10, ST_LOCK = 8'h20, ST_RUN  = 8'h40, ST_WARM = 8'h80
   } rcs_state_t;
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
      logic [3:0]  pstrb;
   } rcs_apb_req_t;
   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } rcs_apb_rsp_t;
endpackage : rcs_pkg

// ---- rtl/rcs_top.sv ----
// rcs_top: reset cause register and cold/warm reset sequencer.
// assumes supply detectors, the reset pin and the oscillator are asynchronous;
// core events arrive as one-cycle pulses on clk_i.
// How it works
// - trap conflict reset sets cause bit 15.
// - illegal opcode, address mode or bad pointer reset sets bit 14.
// - bits 13 to 10 always read zero.
// - configuration mismatch reset sets bit 9.
// - bit 8 one keeps regulator active in sleep, zero puts it in standby.
// - external reset pin sets bit 7.
// - reset instruction sets bit 6.
// - bit 5 enables watchdog; unprogrammed fuse keeps watchdog on anyway.
// - watchdog time-out sets bit 4.
// - sleep sets bit 3, idle sets bit 2.
// - brown-out sets bit 1, which is one after power-on.
// - power-on sets bit 0, which is one after power-on.
// - software may set or clear any implemented bit without causing a reset.
// - power-on or brown-out is cold: cold-start select picks clock.
// - other resets are warm and keep the current clock select.
// - stay in reset until supplies stable and power-up timer done; fetch waits for clock ready.
// - ready delay per mode: start-up, start-up timer, pll lock.
// - start-up timer counts 1024 oscillator periods.
// - pll modes add 1.5 ms lock time.
// - after power-on hold until supply good plus 30 us at most.
// - after brown-out hold until supply good plus 100 us at most.
// - power-up timer holds reset 64 ms, then master reset releases.
// - once clock ready, fetch starts at address zero.
// - clock monitor starts after clock ready plus 900 us at most.
// - power-on clears every cause bit except the power-on and brown-out flags.
// - watchdog flag cleared by power-save, watchdog clear, power-on, brown-out.
`timescale 1ns/1ps
`default_nettype none
module rcs_top #(
   parameter int unsigned BOR_EXT_CYC   = rcs_pkg::BOR_EXT_CYC,
   parameter int unsigned POWERUP_TIMER_CYC      = rcs_pkg::POWERUP_TIMER_CYC,
   parameter int unsigned LOCK_CYC      = rcs_pkg::LOCK_CYC,
   parameter int unsigned CLOCK_FAIL_MONITOR_CYC      = rcs_pkg::CLOCK_FAIL_MONITOR_CYC,
   parameter int unsigned OSCD_LOW_POWER_INTERNAL_OSC_CYC = rcs_pkg::OSCD_LOW_POWER_INTERNAL_OSC_CYC
) (
   input  wire logic                 clk_i,
   input  wire logic                 resetn_i,
   input  wire logic                 ce_i,
   input  wire rcs_pkg::rcs_apb_req_t apb_req_i,
   output var  rcs_pkg::rcs_apb_rsp_t apb_rsp_o,
   input  wire logic                 por_active_i,
   input  wire logic                 bor_active_i,
   input  wire logic                 external_reset_pin_n_i,
   input  wire logic                 osc_clk_i,
   input  wire logic                 trap_conflict_i,
   input  wire logic                 illegal_cond_i,
   input  wire logic                 config_mismatch_i,
   input  wire logic                 sw_reset_instr_i,
   input  wire logic                 wdt_timeout_i,
   input  wire logic                 sleep_entry_i,
   input  wire logic                 idle_entry_i,
   input  wire logic                 power_save_instr_i,
   input  wire logic                 watchdog_clear_instr_i,
   input  wire logic                 watchdog_fuse_enable_i,
   input  wire logic                 clock_fail_monitor_en_i,
   input  wire logic [2:0]           coldstart_clock_select_i,
   output logic                      master_reset_n_o,
   output logic                      fetch_enable_o,
   output logic [23:0]               fetch_addr_o,
   output logic [2:0]                current_clock_select_o,
   output logic                      clock_monitor_en_o,
   output logic                      watchdog_enable_o,
   output logic                      regulator_standby_o
);
   // ---------------------------------------------------------------
   // pin synchronisers: three flops, a level counts once 2nd and 3rd agree
   // bit 0 power-on, 1 brown-out, 2 reset pin (low active), 3 oscillator
   // ---------------------------------------------------------------
   logic [3:0] sync1_r, sync2_r, sync3_r, filt_r;
   wire  [3:0] pins     = {osc_clk_i, external_reset_pin_n_i, bor_active_i, por_active_i};
   wire  [3:0] filt_nxt = (sync2_r & ~(sync2_r ^ sync3_r)) | (filt_r & (sync2_r ^ sync3_r));
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         sync1_r <= 4'h7;
         sync2_r <= 4'h7;
         sync3_r <= 4'h7;
         filt_r  <= 4'h7;
      end else if (ce_i) begin
         sync1_r <= pins;
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
         filt_r  <= filt_nxt;
      end
   end
   wire por_lvl  = filt_r[0];
   wire bor_lvl  = filt_r[1];
   wire pin_rst  = ~filt_r[2];
   wire osc_edge = filt_nxt[3] & ~filt_r[3];  // one rising oscillator period

   // ---------------------------------------------------------------
   // reset cause register
   // ---------------------------------------------------------------
   logic [15:0] rcc_r;
   wire  [15:0] wr_mask  = {{8{apb_req_i.pstrb[1]}}, {8{apb_req_i.pstrb[0]}}};
   wire         acc      = apb_req_i.psel & apb_req_i.penable & apb_rsp_o.pready;
   wire         wr_rcc   = acc & apb_req_i.pwrite & (apb_req_i.paddr == rcs_pkg::RCC_ADDR);
   // software write merges by byte lane; unimplemented bits never store
   wire  [15:0] rcc_sw   = wr_rcc ? (((rcc_r & ~wr_mask) | (apb_req_i.pwdata[15:0] & wr_mask))
                                     & rcs_pkg::RCC_WMASK) : rcc_r;
   // hardware clears first, sets last, so a set in the clear cycle wins
   wire         watchdog_timeout_flag_clr = power_save_instr_i | watchdog_clear_instr_i;
   wire  [15:0] rcc_clr  = bor_lvl ? (rcc_sw & rcs_pkg::BOR_KEEP)
                         : (rcc_sw & ~(16'(watchdog_timeout_flag_clr) << rcs_pkg::WATCHDOG_TIMEOUT_FLAG_B));
   wire  [15:0] hw_set   = (16'(trap_conflict_i)   << rcs_pkg::TRAP_B)
                         | (16'(illegal_cond_i)    << rcs_pkg::ILL_B)
                         | (16'(config_mismatch_i) << rcs_pkg::CM_B)
                         | (16'(pin_rst)           << rcs_pkg::EXT_B)
                         | (16'(sw_reset_instr_i)  << rcs_pkg::SWR_B)
                         | (16'(wdt_timeout_i)     << rcs_pkg::WATCHDOG_TIMEOUT_FLAG_B)
                         | (16'(sleep_entry_i)     << rcs_pkg::SLP_B)
                         | (16'(idle_entry_i)      << rcs_pkg::IDL_B)
                         | (16'(bor_lvl)           << rcs_pkg::BOR_B);
   // power-on holds the register at its power-on value
   wire  [15:0] rcc_nxt  = por_lvl ? rcs_pkg::RCC_RST : (rcc_clr | hw_set);
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         rcc_r <= rcs_pkg::RCC_RST;
      end else if (ce_i) begin
         rcc_r <= rcc_nxt;
      end
   end

   // ---------------------------------------------------------------
   // sequencer: cold path hold, extension, power-up timer, clock ready
   // ---------------------------------------------------------------
   rcs_pkg::rcs_state_t st_r, st_nxt;
   logic [rcs_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
   logic       from_por_r;
   logic       clk_ready_r;
   logic [2:0] clk_sel_r;
   wire        cold    = por_lvl | bor_lvl;
   wire        warm    = pin_rst | trap_conflict_i | illegal_cond_i | config_mismatch_i
                         | sw_reset_instr_i | wdt_timeout_i;
   wire        need_oscd = rcs_pkg::OSCD_MASK[clk_sel_r];
   wire        need_ost  = rcs_pkg::OST_MASK[clk_sel_r];
   wire        need_pll  = rcs_pkg::PLL_MASK[clk_sel_r];
   wire [rcs_pkg::CNT_W-1:0] ext_last  = from_por_r
        ? rcs_pkg::CNT_W'(rcs_pkg::POR_EXT_CYC - 1)
        : rcs_pkg::CNT_W'(BOR_EXT_CYC - 1);
   wire [rcs_pkg::CNT_W-1:0] oscd_last = (clk_sel_r == rcs_pkg::MODE_LOW_POWER_INTERNAL_OSC)
        ? rcs_pkg::CNT_W'(OSCD_LOW_POWER_INTERNAL_OSC_CYC - 1) : rcs_pkg::CNT_W'(rcs_pkg::OSCD_FRC_CYC - 1);
   wire [rcs_pkg::CNT_W-1:0] powerup_timer_last = rcs_pkg::CNT_W'(POWERUP_TIMER_CYC - 1);
   wire [rcs_pkg::CNT_W-1:0] ost_last  = rcs_pkg::CNT_W'(rcs_pkg::OST_PERIODS - 1);
   wire [rcs_pkg::CNT_W-1:0] lock_last = rcs_pkg::CNT_W'(LOCK_CYC - 1);
   // clock-ready stage that follows oscillator start-up in the selected mode
   wire rcs_pkg::rcs_state_t after_oscd = need_ost ? rcs_pkg::ST_OST
                                       : (need_pll ? rcs_pkg::ST_LOCK : rcs_pkg::ST_RUN);

   // next state; a cold source outranks everything
   always_comb begin
      st_nxt  = st_r;
      cnt_nxt = cnt_r + rcs_pkg::CNT_W'(1);
      case (st_r)
         rcs_pkg::ST_HOLD: begin
            cnt_nxt = '0;
            if (!cold) st_nxt = rcs_pkg::ST_EXT;
         end
         rcs_pkg::ST_EXT: begin
            if (cnt_r == ext_last) begin
               st_nxt  = rcs_pkg::ST_POWERUP_TIMER;
               cnt_nxt = '0;
            end
         end
         rcs_pkg::ST_POWERUP_TIMER: begin
            if (cnt_r == powerup_timer_last) begin
               st_nxt  = need_oscd ? rcs_pkg::ST_OSCD : after_oscd;
               cnt_nxt = '0;
            end
         end
         rcs_pkg::ST_OSCD: begin
            if (cnt_r == oscd_last) begin
               st_nxt  = after_oscd;
               cnt_nxt = '0;
            end
         end
         rcs_pkg::ST_OST: begin
            cnt_nxt = osc_edge ? cnt_r + rcs_pkg::CNT_W'(1) : cnt_r;
            if (osc_edge && cnt_r == ost_last) begin
               st_nxt  = need_pll ? rcs_pkg::ST_LOCK : rcs_pkg::ST_RUN;
               cnt_nxt = '0;
            end
         end
         rcs_pkg::ST_LOCK: begin
            if (cnt_r == lock_last) begin
               st_nxt  = rcs_pkg::ST_RUN;
               cnt_nxt = '0;
            end
         end
         rcs_pkg::ST_RUN: begin
            cnt_nxt = '0;
            if (warm) st_nxt = rcs_pkg::ST_WARM;
         end
         rcs_pkg::ST_WARM: begin
            cnt_nxt = '0;
            // clock kept running, so release is one cycle after the source
            if (!warm) st_nxt = clk_ready_r ? rcs_pkg::ST_RUN : rcs_pkg::ST_OSCD;
         end
         default: begin
            st_nxt  = rcs_pkg::ST_HOLD;
            cnt_nxt = '0;
         end
      endcase
      // a warm source during clock start-up must still pull master reset
      if (warm && st_r inside {rcs_pkg::ST_OSCD, rcs_pkg::ST_OST, rcs_pkg::ST_LOCK})
         st_nxt = rcs_pkg::ST_WARM;
      if (cold) begin
         st_nxt  = rcs_pkg::ST_HOLD;
         cnt_nxt = '0;
      end
   end

   // state, counter and cold-start clock pick
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         st_r        <= rcs_pkg::ST_HOLD;
         cnt_r       <= '0;
         from_por_r  <= 1'b1;
         clk_ready_r <= 1'b0;
         clk_sel_r   <= 3'h0;
      end else if (ce_i) begin
         st_r  <= st_nxt;
         cnt_r <= cnt_nxt;
         if (cold) begin
            from_por_r  <= por_lvl;
            clk_ready_r <= 1'b0;
            clk_sel_r   <= coldstart_clock_select_i;
         end else if (st_nxt == rcs_pkg::ST_RUN) begin
            clk_ready_r <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // clock monitor delay: counts from the first ready cycle, warm
   // resets do not restart it since the clock never stopped
   // ---------------------------------------------------------------
   logic [rcs_pkg::CNT_W-1:0] clock_fail_monitor_cnt_r;
   wire clock_fail_monitor_done = (clock_fail_monitor_cnt_r == rcs_pkg::CNT_W'(CLOCK_FAIL_MONITOR_CYC));
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         clock_fail_monitor_cnt_r <= '0;
      end else if (ce_i) begin
         if (!clk_ready_r) clock_fail_monitor_cnt_r <= '0;
         else if (!clock_fail_monitor_done) clock_fail_monitor_cnt_r <= clock_fail_monitor_cnt_r + rcs_pkg::CNT_W'(1);
      end
   end

   // ---------------------------------------------------------------
   // registered outputs
   // ---------------------------------------------------------------
   wire mrst_n_nxt = !(st_nxt == rcs_pkg::ST_HOLD || st_nxt == rcs_pkg::ST_EXT
                    || st_nxt == rcs_pkg::ST_POWERUP_TIMER || st_nxt == rcs_pkg::ST_WARM);
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         master_reset_n_o       <= 1'b0;
         fetch_enable_o         <= 1'b0;
         fetch_addr_o           <= 24'h000000;
         current_clock_select_o <= 3'h0;
         clock_monitor_en_o     <= 1'b0;
         watchdog_enable_o      <= 1'b1;
         regulator_standby_o    <= 1'b1;
      end else if (ce_i) begin
         master_reset_n_o       <= mrst_n_nxt;
         fetch_enable_o         <= (st_nxt == rcs_pkg::ST_RUN);
         fetch_addr_o           <= 24'h000000;
         current_clock_select_o <= clk_sel_r;
         clock_monitor_en_o     <= clock_fail_monitor_en_i & clock_fail_monitor_done;
         watchdog_enable_o      <= watchdog_fuse_enable_i | rcc_r[rcs_pkg::WDTEN_B];
         regulator_standby_o    <= ~rcc_r[rcs_pkg::VREG_B];
      end
   end

   // ---------------------------------------------------------------
   // apb slave: zero wait states, answer decoded in the setup cycle
   // ---------------------------------------------------------------
   wire        setup   = apb_req_i.psel & ~apb_req_i.penable;
   wire        hit_rcc = (apb_req_i.paddr == rcs_pkg::RCC_ADDR);
   wire        hit_seq = (apb_req_i.paddr == rcs_pkg::SEQ_ADDR);
   wire [31:0] seq_stat = {18'h00000, clock_fail_monitor_done, clk_ready_r, master_reset_n_o,
                           clk_sel_r, st_r};
   wire [31:0] rd_mux  = hit_rcc ? {16'h0000, rcc_r} : (hit_seq ? seq_stat : 32'h00000000);
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         apb_rsp_o <= '0;
      end else if (ce_i) begin
         apb_rsp_o.pready  <= setup;
         apb_rsp_o.pslverr <= setup & ~(hit_rcc | hit_seq);
         apb_rsp_o.prdata  <= (setup & ~apb_req_i.pwrite) ? rd_mux : 32'h00000000;
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   property p_unimpl;
      @(posedge clk_i) disable iff (!resetn_i) rcc_r[13:10] == 4'h0;
   endproperty
   a_unimpl: assert property (p_unimpl) else $error("unimplemented bits set");

   property p_trap;
      @(posedge clk_i) disable iff (!resetn_i)
         ce_i && trap_conflict_i && !por_lvl |=> rcc_r[rcs_pkg::TRAP_B];
   endproperty
   a_trap: assert property (p_trap) else $error("trap flag not set");

   property p_ill;
      @(posedge clk_i) disable iff (!resetn_i)
         ce_i && illegal_cond_i && !por_lvl |=> rcc_r[rcs_pkg::ILL_B] && !master_reset_n_o;
   endproperty
   a_ill: assert property (p_ill) else $error("illegal flag or reset missing");

   property p_swr;
      @(posedge clk_i) disable iff (!resetn_i)
         ce_i && sw_reset_instr_i && !por_lvl |=> rcc_r[rcs_pkg::SWR_B];
   endproperty
   a_swr: assert property (p_swr) else $error("software reset flag not set");

   property p_por;
      @(posedge clk_i) disable iff (!resetn_i)
         ce_i && por_lvl |=> rcc_r == rcs_pkg::RCC_RST && !master_reset_n_o;
   endproperty
   a_por: assert property (p_por) else $error("power-on did not clear causes");

   property p_watchdog_timeout_flag_clr;
      @(posedge clk_i) disable iff (!resetn_i)
         ce_i && watchdog_clear_instr_i && !wdt_timeout_i && !wr_rcc && !por_lvl
         |=> !rcc_r[rcs_pkg::WATCHDOG_TIMEOUT_FLAG_B];
   endproperty
   a_watchdog_timeout_flag_clr: assert property (p_watchdog_timeout_flag_clr) else $error("watchdog flag not cleared");

   property p_wdt_en;
      @(posedge clk_i) disable iff (!resetn_i)
         ce_i && watchdog_fuse_enable_i |=> watchdog_enable_o;
   endproperty
   a_wdt_en: assert property (p_wdt_en) else $error("fuse did not force watchdog");

   property p_release;
      @(posedge clk_i) disable iff (!resetn_i)
         $rose(master_reset_n_o) |-> $past(st_r) inside {rcs_pkg::ST_POWERUP_TIMER, rcs_pkg::ST_WARM};
   endproperty
   a_release: assert property (p_release) else $error("master reset released early");

   property p_fetch;
      @(posedge clk_i) disable iff (!resetn_i)
         fetch_enable_o |-> master_reset_n_o && clk_ready_r && fetch_addr_o == 24'h000000;
   endproperty
   a_fetch: assert property (p_fetch) else $error("fetch before clock ready");

   property p_clock_fail_monitor;
      @(posedge clk_i) disable iff (!resetn_i)
         $rose(clock_monitor_en_o) |-> $past(clock_fail_monitor_cnt_r) == rcs_pkg::CNT_W'(CLOCK_FAIL_MONITOR_CYC);
   endproperty
   a_clock_fail_monitor: assert property (p_clock_fail_monitor) else $error("clock monitor started early");

   property p_sw_no_rst;
      @(posedge clk_i) disable iff (!resetn_i)
         ce_i && wr_rcc && st_r == rcs_pkg::ST_RUN && !warm && !cold |=> master_reset_n_o;
   endproperty
   a_sw_no_rst: assert property (p_sw_no_rst) else $error("register write caused reset");
endmodule : rcs_top
`default_nettype wire

// ---- tb/rcs_partner.sv ----
// rcs_partner: supply detectors, reset pin and oscillator seen by the block.
// assumes the bench commands supply dips and pin presses as levels.
`timescale 1ns/1ps
`default_nettype none
module rcs_partner (
   input  wire logic por_cmd_i,
   input  wire logic bor_cmd_i,
   input  wire logic pin_cmd_i,
   output logic      por_active_o,
   output logic      bor_active_o,
   output logic      pin_n_o,
   output logic      osc_clk_o
);
   // ------------------------------------------------------------
   // detectors follow the commanded supply level
   // ------------------------------------------------------------
   assign por_active_o = por_cmd_i;
   assign bor_active_o = bor_cmd_i;
   assign pin_n_o      = ~pin_cmd_i;  // pin tied high when not pressed
   // crystal runs free at 80 ns, kept slower than a quarter of clk_i
   initial begin
      osc_clk_o = 1'b0;
      forever #40 osc_clk_o = ~osc_clk_o;
   end
endmodule : rcs_partner
`default_nettype wire

// ---- tb/testbench.sv ----
// testbench: directed checks of the reset cause register and sequencer.
// assumes rcs_pkg, rcs_top and rcs_partner are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic                  clk_i, resetn_i, por, bor, pin, fuse, fmon, ps, wc, err, lo, ce;
   logic                  por_a, bor_a, pin_n, osc, mrst_n, fetch, mon, wdt_en, vstby;
   logic [2:0]            csel, cur;
   logic [6:0]            ev;
   logic [23:0]           faddr;
   logic [31:0]           rd;
   rcs_pkg::rcs_apb_req_t req;
   rcs_pkg::rcs_apb_rsp_t rsp;
   int                    num_errors, total_checks, waited;
   int                    bits[7] = '{15, 14, 9, 6, 4, 3, 2};
   // short counts keep the run small
   rcs_top #(.BOR_EXT_CYC(20), .POWERUP_TIMER_CYC(50), .LOCK_CYC(30), .CLOCK_FAIL_MONITOR_CYC(40),
      .OSCD_LOW_POWER_INTERNAL_OSC_CYC(25)) i_dut (.clk_i, .resetn_i, .ce_i(ce), .apb_req_i(req),
      .apb_rsp_o(rsp), .por_active_i(por_a), .bor_active_i(bor_a),
      .external_reset_pin_n_i(pin_n), .osc_clk_i(osc), .trap_conflict_i(ev[0]),
      .illegal_cond_i(ev[1]), .config_mismatch_i(ev[2]), .sw_reset_instr_i(ev[3]),
      .wdt_timeout_i(ev[4]), .sleep_entry_i(ev[5]), .idle_entry_i(ev[6]),
      .power_save_instr_i(ps), .watchdog_clear_instr_i(wc),
      .watchdog_fuse_enable_i(fuse), .clock_fail_monitor_en_i(fmon),
      .coldstart_clock_select_i(csel), .master_reset_n_o(mrst_n),
      .fetch_enable_o(fetch), .fetch_addr_o(faddr), .current_clock_select_o(cur),
      .clock_monitor_en_o(mon), .watchdog_enable_o(wdt_en), .regulator_standby_o(vstby));
   rcs_partner i_part (.por_cmd_i(por), .bor_cmd_i(bor), .pin_cmd_i(pin),
      .por_active_o(por_a), .bor_active_o(bor_a), .pin_n_o(pin_n), .osc_clk_o(osc));
   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // one apb transfer; waits on pready, never on a fixed count
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      req <= '{1'b1, 1'b0, w, a, d, 4'hf};
      @(posedge clk_i);
      req.penable <= 1'b1;
      do begin
         @(posedge clk_i);
         n++;
      end while (rsp.pready !== 1'b1);
      rd = rsp.prdata;
      err = rsp.pslverr;
      chk("access cycles", n, 32'h1);
      req <= '0;
      @(posedge clk_i);
   endtask : apb
   task automatic wait_run(input int lim);
      waited = 0;
      while (fetch !== 1'b1 && waited < lim) begin
         @(posedge clk_i);
         waited++;
      end
      chk("fetch", {31'h0, fetch}, 32'h1);
   endtask : wait_run
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_power();
      repeat (20) @(posedge clk_i);
      por <= 1'b0;
      repeat (100) @(posedge clk_i);
      chk("held", {31'h0, mrst_n}, 32'h0);
      wait_run(5000);
      chk("mrst", {31'h0, mrst_n}, 32'h1);
      chk("cur", {29'h0, cur}, 32'h0);
      chk("addr", {8'h0, faddr}, 32'h0);
      repeat (45) @(posedge clk_i);
      chk("mon", {31'h0, mon}, 32'h1);
      fmon <= 1'b0;
      repeat (2) @(posedge clk_i);
      chk("mon off", {31'h0, mon}, 32'h0);
      fmon <= 1'b1;
      apb(1'b0, 12'h000, 32'h0);
      chk("por val", rd, 32'h3);
      apb(1'b0, 12'h008, 32'h0);
      chk("unmapped", {err, rd[30:0]}, 32'h80000000);
   endtask : t_power
   task automatic t_regs();
      apb(1'b1, 12'h000, 32'hffff);
      apb(1'b0, 12'h000, 32'h0);
      chk("all ones", rd, 32'hc3ff);
      chk("no reset", 32'({mrst_n, wdt_en, vstby}), 32'h6);
      apb(1'b1, 12'h000, 32'h0);
      apb(1'b0, 12'h000, 32'h0);
      chk("zeros", 32'({rd[15:0], wdt_en, vstby}), 32'h1);
      // a sleep entry while the clock enable is low must not be taken
      ce <= 1'b0;
      ev <= 7'h20;
      @(posedge clk_i);
      ev <= '0;
      ce <= 1'b1;
      apb(1'b0, 12'h000, 32'h0);
      chk("frozen", rd, 32'h0);
      fuse <= 1'b1;
      repeat (2) @(posedge clk_i);
      chk("fuse", {31'h0, wdt_en}, 32'h1);
      fuse <= 1'b0;
   endtask : t_regs
   // brown-out into a crystal pll mode: start-up timer and lock both run
   task automatic t_bor();
      apb(1'b1, 12'h000, 32'h00d1);
      csel <= 3'h3;
      bor <= 1'b1;
      repeat (10) @(posedge clk_i);
      bor <= 1'b0;
      wait_run(20000);
      chk("ost", {31'h0, waited >= 8192}, 32'h1);
      chk("cold sel", {29'h0, cur}, 32'h3);
      apb(1'b0, 12'h000, 32'h0);
      chk("bor val", rd, 32'h0083);
      apb(1'b1, 12'h000, 32'h0);
   endtask : t_bor
   task automatic t_events();
      csel <= 3'h0;
      for (int i = 0; i < 7; i++) begin
         ev <= 7'h01 << i;
         @(posedge clk_i);
         ev <= '0;
         lo = 1'b0;
         repeat (6) begin
            @(posedge clk_i);
            lo = lo | (mrst_n === 1'b0);
         end
         chk("warm", {31'h0, lo}, {31'h0, i < 5});
         wait_run(500);
         chk("warm sel", {29'h0, cur}, 32'h3);
         apb(1'b0, 12'h000, 32'h0);
         chk("cause", rd, 32'h1 << bits[i]);
         apb(1'b1, 12'h000, 32'h0);
      end
   endtask : t_events
   task automatic t_pin();
      pin <= 1'b1;
      repeat (10) @(posedge clk_i);
      pin <= 1'b0;
      repeat (10) @(posedge clk_i);
      wait_run(500);
      apb(1'b0, 12'h000, 32'h0);
      chk("pin", rd, 32'h80);
   endtask : t_pin
   // watchdog flag cleared by each of the two instructions
   task automatic t_wdt();
      for (int k = 0; k < 2; k++) begin
         ev <= 7'h10;
         @(posedge clk_i);
         ev <= '0;
         repeat (6) @(posedge clk_i);
         wait_run(500);
         ps <= (k == 0);
         wc <= (k == 1);
         @(posedge clk_i);
         ps <= 1'b0;
         wc <= 1'b0;
         apb(1'b0, 12'h000, 32'h0);
         chk("wdt clr", {31'h0, rd[4]}, 32'h0);
      end
   endtask : t_wdt
   task automatic summarize();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : summarize
   // ------------------------------------------------------------
   // clock, main sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   initial begin
      {resetn_i, bor, pin, fuse, ps, wc, ev, csel, req} = '0;
      {por, fmon, ce} = 3'b111;
      num_errors = 0;
      total_checks = 0;
      repeat (2) @(posedge clk_i);
      resetn_i <= 1'b1;
      t_power();
      t_regs();
      t_bor();
      t_events();
      t_pin();
      t_wdt();
      summarize();
   end
   // whole run needs well under 30000 cycles; give up at 40000
   initial begin
      #400000;
      num_errors++;
      summarize();
   end
endmodule : testbench
`default_nettype wire
